// >>> dv/cpmc_sys_model.sv
// system-side model: acks quiesce after a delay, raises ext interrupt
// assumes one clock shared with the controller, all lines active high
`timescale 1ns/1ps
module cpmc_sys_model #(parameter int RELOCK = 8) (
    input wire logic i_sys_clk,
    input wire logic [2:0] i_ack_delay,
    input wire logic i_quiesce_req,
    input wire logic i_pll_stop_ok,
    input wire logic i_wake,
    output logic o_quiesce_ack = 1'b0,
    output logic o_ext_int = 1'b0
);
    int q_cnt = 0;
    int r_cnt = 0;
    logic slept = 1'b0;
    // ack held for as long as the request stands
    always @(posedge i_sys_clk) begin
        if (!i_quiesce_req) begin
            q_cnt <= 0;
            o_quiesce_ack <= 1'b0;
        end else if (q_cnt < int'(i_ack_delay)) begin
            q_cnt <= q_cnt + 1;
        end else begin
            o_quiesce_ack <= 1'b1;
        end
    end
    // after sleep the clock must relock, RELOCK cycles, before the ext interrupt rises
    always @(posedge i_sys_clk) begin
        if (!i_wake) begin
            r_cnt <= 0;
            slept <= i_pll_stop_ok;
            o_ext_int <= 1'b0;
        end else if (slept && r_cnt < RELOCK) begin
            r_cnt <= r_cnt + 1;
        end else begin
            o_ext_int <= 1'b1;
        end
    end
endmodule : cpmc_sys_model

// >>> dv/test_cpmc_core.sv
// bench for the power-mode controller: gating, doze, nap, sleep, reset
// assumes the system model answers quiesce and drives the ext interrupt
`timescale 1ns/1ps
`include "cpmc_consts.svh"
module test_cpmc_core;
    import cpmc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, pow = 1'b0, hit = 1'b0, pdone = 1'b0;
    logic [31:0] cfg = 32'h0;
    logic [`CPMC_NUM_UNITS-1:0] dem = 6'h0, en;
    logic [4:0] src = 5'h0;
    logic [2:0] dly = 3'h0;
    logic ack, ext, tb, snp, dc, pll, qreq, smi_t, ext_t, pclr;
    cpmc_mode_t mode, last = CPMC_M_FULL;
    cpmc_mode_t expq[$];
    int n_mismatch = 0, compares = 0, i;
    cpmc_core u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_impl_config_register(cfg),
        .i_pow_request(pow), .i_unit_demand(dem), .i_ext_int(ext), .i_smi(src[1]),
        .i_mcheck(src[2]), .i_soft_reset(src[3]), .i_dec_event(src[4]),
        .i_snoop_hit(hit), .i_push_done(pdone), .i_quiesce_ack(ack), .o_unit_clk_en(en),
        .o_timebase_clk_en(tb), .o_snoop_en(snp), .o_dcache_en(dc), .o_pll_stop_ok(pll),
        .o_quiesce_req(qreq), .o_smi_take(smi_t), .o_ext_int_take(ext_t),
        .o_pow_clear(pclr), .o_mode(mode));
    cpmc_sys_model #(.RELOCK(8)) u_sys (.i_sys_clk(clk), .i_ack_delay(dly),
        .i_quiesce_req(qreq), .i_pll_stop_ok(pll), .i_wake(src[0]),
        .o_quiesce_ack(ack), .o_ext_int(ext));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic report_and_stop;
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // bounded wait; the watcher judges the change itself
    task automatic wait_mode(input cpmc_mode_t m);
        int k;
        for (k = 0; k < 40 && mode !== m; k++) @(negedge clk);
        if (mode !== m) chk("mode wait", m, mode);
    endtask : wait_mode
    // request dropped once low, so no second entry after wake
    task automatic enter(input int b, input cpmc_mode_t m);
        @(posedge clk) begin
            cfg <= (cfg & ~32'h0000_0700) | (32'h1 << b);
            pow <= 1'b1;
            expq.push_back(m);
        end
        wait_mode(m);
        @(posedge clk) pow <= 1'b0;
        @(negedge clk);
    endtask : enter
    task automatic wake(input int s);
        @(posedge clk) begin
            expq.push_back(CPMC_M_FULL);
            src <= 5'(1 << s);
        end
        wait_mode(CPMC_M_FULL);
        @(posedge clk) src <= 5'h0;
        // clear pulse stands only in the cycle full power returns
        @(negedge clk);
        chk("pow clear", 1, pclr);
    endtask : wake
    task automatic full_chk;
        chk("reset outs", 10'h3FC, {en, tb, snp, qreq, pll});
    endtask : full_chk
    initial begin
        forever #20 clk = ~clk;
    end
    // every mode change must match the oldest expected entry
    // sampled mid-cycle, where the registered mode has settled
    always @(negedge clk) begin
        if (mode !== last) begin
            if (expq.size() == 0) chk("mode unexpected", last, mode);
            else chk("mode", expq.pop_front(), mode);
            if (mode == CPMC_M_NAP || mode == CPMC_M_SLEEP) chk("ack", 1, ack);
            last = mode;
        end
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #(40 * 20000);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        void'($urandom(89298));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        full_chk();
        // gating off first, then per-unit demand with float unit idle
        for (i = 0; i < 16; i++) begin
            @(posedge clk) cfg[`CPMC_BIT_UCG] <= (i >= 8);
            dem <= (i == 9) ? 6'h3B : 6'($urandom);
            repeat (2) @(negedge clk);
            chk("unit en", (i >= 8) ? dem : 6'h3F, en);
        end
        // doze then nap, each woken by every source in turn
        for (i = 0; i < 10; i++) begin
            @(posedge clk) dly <= 3'($urandom_range(6));
            if (i < 5) enter(`CPMC_BIT_DOZE, CPMC_M_DOZE);
            else enter(`CPMC_BIT_NAP, CPMC_M_NAP);
            chk("low outs", (i < 5) ? 10'h00C : 10'h009, {en, tb, snp, dc, qreq});
            if (i == 0) begin
                @(posedge clk) hit <= 1'b1;
                @(posedge clk) hit <= 1'b0;
                repeat (3) @(negedge clk);
                chk("dcache hit", 1, dc);
                @(posedge clk) pdone <= 1'b1;
                @(posedge clk) pdone <= 1'b0;
                repeat (3) @(negedge clk);
                chk("dcache push", 0, dc);
            end
            wake(i % 5);
            @(negedge clk);
            chk("qreq wake", 0, qreq);
        end
        enter(`CPMC_BIT_SLEEP, CPMC_M_SLEEP);
        chk("sleep outs", 11'h003, {en, tb, snp, dc, qreq, pll});
        @(posedge clk) src <= 5'h10;
        repeat (12) @(posedge clk);
        src <= 5'h0;
        wake(0);
        @(posedge clk) begin
            cfg <= 32'h0;
            pow <= 1'b1;
        end
        repeat (12) @(negedge clk);
        chk("qreq no mode", 0, qreq);
        @(posedge clk) begin
            pow <= 1'b0;
            cfg <= 32'h100;
            src <= 5'h2;
        end
        repeat (5) @(negedge clk);
        chk("take smi", 2'h2, {smi_t, ext_t});
        @(posedge clk) src <= 5'h1;
        repeat (5) @(negedge clk);
        chk("take ext", 2'h1, {smi_t, ext_t});
        @(posedge clk) src <= 5'h0;
        enter(`CPMC_BIT_DOZE, CPMC_M_DOZE);
        expq.push_back(CPMC_M_FULL);
        @(posedge clk) begin
            cfg <= 32'h0;
            rst_n <= 1'b0;
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        full_chk();
        report_and_stop();
    end
endmodule : test_cpmc_core

// >>> inc/cpmc_consts.svh
// constants for the core power-mode controller: mode bit positions, reset
// values and cycle counts. assumes a 25 MHz processor clock.
// Overview of operation
// - per-unit clock enable decided each cycle
// - float unit unclocked while no float work
// - gating invisible to software and hardware
// - gating only after software sets enable bit
// - reset gives full power, gating off
// - gating off in full power clocks everything
// - separate system-management interrupt with own vector
// - interrupts redirect; only software enters low power
// - state chosen by machine-state and config bits
// - doze keeps time base, snoop, PLL alive
// - doze wakes on interrupts, decrementer, resets, check
// - doze snoop hit: cache on, push, off
// - nap also stops snooping
// - nap wakes quickly on same sources
// - sleep stops all units before PLL stops
// - low-power changes always pass through full power
// - quiesce handshake before nap or sleep
// - mode bits 8,9,10; entry after power request
// - quiesce acknowledge held throughout nap or sleep
// - quiesce request dropped before any bus transaction
`ifndef CPMC_CONSTS_SVH
`define CPMC_CONSTS_SVH
`define CPMC_BIT_DOZE 8
`define CPMC_BIT_NAP 9
`define CPMC_BIT_SLEEP 10
`define CPMC_BIT_UCG 11
`define CPMC_CFG_RESET 32'h0000_0000
`define CPMC_NUM_UNITS 6
`define CPMC_UNIT_FPU 2
`define CPMC_ENTRY_NS 160
`define CPMC_CLK_NS 40
`define CPMC_ENTRY_CYC ((`CPMC_ENTRY_NS + `CPMC_CLK_NS - 1) / `CPMC_CLK_NS)
`define CPMC_WAKE_NS 80
`define CPMC_WAKE_CYC (`CPMC_WAKE_NS / `CPMC_CLK_NS)
`endif

// >>> inc/cpmc_pkg.sv
// types for the core power-mode controller
// assumes the constants header is included by the design file
package cpmc_pkg;
    // gray codes along full -> settle -> quiesce -> low -> wake
    typedef enum logic [2:0] {
        CPMC_FULL = 3'h0,
        CPMC_SETTLE = 3'h1,
        CPMC_QUIESCE = 3'h3,
        CPMC_LOW = 3'h2,
        CPMC_WAKE = 3'h6,
        CPMC_PUSH = 3'h7
    } cpmc_state_t;
    typedef enum logic [1:0] {
        CPMC_M_FULL = 2'h0,
        CPMC_M_DOZE = 2'h1,
        CPMC_M_NAP = 2'h2,
        CPMC_M_SLEEP = 2'h3
    } cpmc_mode_t;
endpackage : cpmc_pkg

// >>> verilog/cpmc_core.sv
// core power-mode controller: unit clock enables, doze/nap/sleep sequencing
// and the quiesce handshake. assumes wake sources and quiesce acknowledge
// come from outside the clock domain; demand bits come from dispatch logic.
`timescale 1ns/1ps
`include "cpmc_consts.svh"
module cpmc_core (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [31:0] i_impl_config_register,
    input wire logic i_pow_request,
    input wire logic [`CPMC_NUM_UNITS-1:0] i_unit_demand,
    input wire logic i_ext_int,
    input wire logic i_smi,
    input wire logic i_mcheck,
    input wire logic i_soft_reset,
    input wire logic i_dec_event,
    input wire logic i_snoop_hit,
    input wire logic i_push_done,
    input wire logic i_quiesce_ack,
    output logic [`CPMC_NUM_UNITS-1:0] o_unit_clk_en,
    output logic o_timebase_clk_en,
    output logic o_snoop_en,
    output logic o_dcache_en,
    output logic o_pll_stop_ok,
    output logic o_quiesce_req,
    output logic o_smi_take,
    output logic o_ext_int_take,
    output logic o_pow_clear,
    output cpmc_pkg::cpmc_mode_t o_mode
);
    import cpmc_pkg::*;

    localparam logic [3:0] ENTRY_CYC = 4'(`CPMC_ENTRY_CYC);
    localparam logic [3:0] WAKE_CYC = 4'(`CPMC_WAKE_CYC);

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // wake pins and acknowledge are asynchronous: two flops each
    logic [5:0] async_in;
    logic [5:0] sync_meta_reg;
    logic [5:0] sync_reg;
    assign async_in = {i_quiesce_ack, i_dec_event, i_soft_reset, i_mcheck, i_smi, i_ext_int};
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sync_meta_reg <= 6'h00;
            sync_reg <= 6'h00;
        end else begin
            sync_meta_reg <= async_in;
            sync_reg <= sync_meta_reg;
        end
    end

    wire ext_int_s = sync_reg[0];
    wire smi_s = sync_reg[1];
    wire mcheck_s = sync_reg[2];
    wire soft_rst_s = sync_reg[3];
    wire dec_s = sync_reg[4];
    wire qack_s = sync_reg[5];

    // mode selection from config bits; sleep outranks nap outranks doze
    wire bit_doze = i_impl_config_register[`CPMC_BIT_DOZE];
    wire bit_nap = i_impl_config_register[`CPMC_BIT_NAP];
    wire bit_sleep = i_impl_config_register[`CPMC_BIT_SLEEP];
    wire gating_on = i_impl_config_register[`CPMC_BIT_UCG];
    cpmc_mode_t sel_mode;
    assign sel_mode = bit_sleep ? CPMC_M_SLEEP : bit_nap ? CPMC_M_NAP :
        bit_doze ? CPMC_M_DOZE : CPMC_M_FULL;
    wire req_valid = i_pow_request && (sel_mode != CPMC_M_FULL);

    cpmc_state_t state_reg;
    cpmc_state_t state_next;
    cpmc_mode_t mode_reg;
    cpmc_mode_t mode_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // wake sources per mode: no decrementer wake from sleep
    wire wake_common = ext_int_s | smi_s | mcheck_s | soft_rst_s;
    wire wake_any = wake_common | (dec_s & (mode_reg != CPMC_M_SLEEP));
    wire needs_quiesce = (mode_reg == CPMC_M_NAP) || (mode_reg == CPMC_M_SLEEP);

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            CPMC_FULL: begin
                // only a software request enters low power
                if (req_valid) begin
                    state_next = CPMC_SETTLE;
                    mode_next = sel_mode;
                    cnt_next = ENTRY_CYC;
                end
            end
            CPMC_SETTLE: begin
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (needs_quiesce) begin
                    state_next = CPMC_QUIESCE;
                end else begin
                    state_next = CPMC_LOW;
                end
            end
            CPMC_QUIESCE: begin
                // wait for acknowledge; a wake here aborts entry
                if (wake_any) begin
                    state_next = CPMC_WAKE;
                    cnt_next = WAKE_CYC;
                end else if (qack_s) begin
                    state_next = CPMC_LOW;
                end
            end
            CPMC_LOW: begin
                if (wake_any) begin
                    state_next = CPMC_WAKE;
                    cnt_next = WAKE_CYC;
                end else if (i_snoop_hit && mode_reg == CPMC_M_DOZE) begin
                    state_next = CPMC_PUSH;
                end
            end
            CPMC_PUSH: begin
                // back to doze once write-back finishes
                if (i_push_done) begin
                    state_next = CPMC_LOW;
                end
            end
            CPMC_WAKE: begin
                // always return to full power before any new mode
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    state_next = CPMC_FULL;
                    mode_next = CPMC_M_FULL;
                end
            end
            default: begin
                state_next = CPMC_FULL;
                mode_next = CPMC_M_FULL;
            end
        endcase
    end

    // state registers; reset leaves full power with gating off
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= CPMC_FULL;
            mode_reg <= CPMC_M_FULL;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
        end
    end

    wire in_full = (state_reg == CPMC_FULL) || (state_reg == CPMC_SETTLE);
    wire in_low = (state_reg == CPMC_LOW) || (state_reg == CPMC_PUSH);
    wire waking = (state_reg == CPMC_WAKE);

    // per-unit enables; demand lead keeps gating invisible to timing
    logic [`CPMC_NUM_UNITS-1:0] unit_en_next;
    genvar u;
    generate
        for (u = 0; u < `CPMC_NUM_UNITS; u++) begin : g_unit
            assign unit_en_next[u] = (in_full || waking) &&
                (!gating_on || i_unit_demand[u]);
        end
    endgenerate

    // output registers
    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_unit_clk_en <= {`CPMC_NUM_UNITS{1'b1}};
            o_timebase_clk_en <= 1'b1;
            o_snoop_en <= 1'b1;
            o_dcache_en <= 1'b1;
            o_pll_stop_ok <= 1'b0;
            o_quiesce_req <= 1'b0;
            o_smi_take <= 1'b0;
            o_ext_int_take <= 1'b0;
            o_pow_clear <= 1'b0;
            o_mode <= CPMC_M_FULL;
        end else begin
            o_unit_clk_en <= unit_en_next;
            // time base runs except in sleep
            o_timebase_clk_en <= !(in_low && mode_reg == CPMC_M_SLEEP);
            // snoop stays in doze, stops once quiesce is granted
            o_snoop_en <= !(in_low && needs_quiesce);
            o_dcache_en <= !in_low || (state_next == CPMC_PUSH);
            o_pll_stop_ok <= (state_reg == CPMC_LOW) && (mode_reg == CPMC_M_SLEEP);
            o_quiesce_req <= (state_next == CPMC_QUIESCE) ||
                (state_next == CPMC_LOW && needs_quiesce);
            o_smi_take <= smi_s;
            o_ext_int_take <= ext_int_s;
            o_pow_clear <= (state_reg == CPMC_WAKE) && (state_next == CPMC_FULL);
            o_mode <= in_low ? mode_reg : CPMC_M_FULL;
        end
    end

    // checks, all on the processor clock and released with the internal reset
    chk_full_after_reset: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        !gating_on && in_full |=> &o_unit_clk_en)
        else $error("unit clock dropped with gating off");

    chk_no_ack_no_nap: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_QUIESCE && state_next == CPMC_LOW |-> qack_s)
        else $error("nap or sleep entered without acknowledge");

    chk_qreq_off_wake: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_WAKE |=> !o_quiesce_req)
        else $error("quiesce request held after wake");

    chk_ignore_empty_req: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_FULL && sel_mode == CPMC_M_FULL |=> state_reg == CPMC_FULL)
        else $error("left full power with no mode bit");

    chk_low_via_full: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_WAKE && $past(state_reg) != CPMC_WAKE |->
            ##[1:3] state_reg == CPMC_FULL)
        else $error("wake did not reach full power");

    chk_sleep_no_dec: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_LOW && mode_reg == CPMC_M_SLEEP && !wake_common |=>
            state_reg != CPMC_WAKE)
        else $error("sleep left without a sleep wake source");

    chk_entry_delay: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_FULL && req_valid |=> state_reg == CPMC_SETTLE [*4])
        else $error("low-power entry delay wrong");

    chk_doze_snoop: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_LOW && mode_reg == CPMC_M_DOZE |=> o_snoop_en && o_timebase_clk_en)
        else $error("doze lost snoop or time base");

    chk_fpu_idle: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        gating_on && !i_unit_demand[`CPMC_UNIT_FPU] |=> !o_unit_clk_en[`CPMC_UNIT_FPU])
        else $error("float unit clocked while idle");

    // reset leaves every unit clocked and no handshake pending
    chk_reset_full_power: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        $rose(rst_n_reg) |-> &o_unit_clk_en && o_snoop_en && !o_quiesce_req)
        else $error("reset did not leave full power");

    // a wake pin alone never moves the sequencer out of full power
    chk_int_no_entry: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_FULL && !req_valid |=> state_reg == CPMC_FULL)
        else $error("low power entered without a software request");

    // nap and sleep drop snooping once the quiesce is granted
    chk_nap_no_snoop: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_LOW && needs_quiesce |=> !o_snoop_en)
        else $error("snoop left on in nap or sleep");

    // the clock may only be stopped with every unit already idle
    chk_sleep_all_off: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        o_pll_stop_ok |-> !o_timebase_clk_en && !(|o_unit_clk_en) && !o_snoop_en)
        else $error("pll stop allowed with units still clocked");

    // the cache stays on for the whole write-back
    chk_push_dcache_on: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_PUSH |-> o_dcache_en)
        else $error("data cache off during snoop push");

    // a wake in doze or nap is back in full power within a few cycles
    chk_wake_few_cycles: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_LOW && wake_any |-> ##[1:3] o_mode == CPMC_M_FULL)
        else $error("wake took too long");

    // management interrupt keeps a take of its own, one cycle behind its synchronised pin
    chk_smi_own_vector: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        o_smi_take == $past(smi_s))
        else $error("management interrupt take does not follow its pin");

    // external interrupt only redirects, through its own take
    chk_ext_own_vector: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        o_ext_int_take == $past(ext_int_s))
        else $error("external interrupt take does not follow its pin");

    // the quiesce request stands for the whole nap or sleep
    chk_qreq_stands: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        state_reg == CPMC_LOW && needs_quiesce && !wake_any |=> o_quiesce_req)
        else $error("quiesce request dropped inside nap or sleep");

    // one clear pulse per return, on the cycle full power is back
    chk_pow_clear_pulse: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        o_pow_clear |-> state_reg == CPMC_FULL ##1 !o_pow_clear)
        else $error("power-request clear pulse misplaced");
endmodule : cpmc_core
